// ### hdl/srd_cfg.svh
// constants for the safety release, acknowledge and off-delay block
`ifndef SRD_CFG_SVH
`define SRD_CFG_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define SRD_OFS_CTRL    8'h00
`define SRD_OFS_FIX     8'h04
`define SRD_OFS_ADJ0    8'h08
`define SRD_OFS_STATUS  8'h18
`define SRD_OFS_FIXREM  8'h1c
`define SRD_OFS_ADJREM  8'h20
// ---------------------------------------------------------------
// control fields and reset values
// ---------------------------------------------------------------
`define SRD_CTRL_RUN    0
`define SRD_CTRL_RSTL   1
`define SRD_CTRL_RSRL   2
`define SRD_CTRL_RSTN   4
`define SRD_CTRL_RSRN   8
`define SRD_NACT_RST    3'h7
`define SRD_DLY_RST     16'h0000
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SRD_CLK_HZ      40000000
`define SRD_LOGIC_US    1000
`define SRD_STEP_MS     10
`define SRD_BLINK_MS    500
`define SRD_ACK_SHORT_MS 100
`define SRD_ACK_LONG_MS 350
`define SRD_ACK_MAX_MS  30000
`define SRD_FIX_MAX     30000
`define SRD_ADJ_MAX     60000
`endif

// ### hdl/srd_pkg.sv
// types shared by the safety release block
package srd_pkg;
    typedef enum logic [1:0] {
        SRD_HOLD = 2'b00,
        SRD_RUN  = 2'b01,
        SRD_OFF  = 2'b10
    } srd_dly_state_t;
endpackage

// ### hdl/srd_ack_gate.sv
// manual acknowledge gate, used for both reset and restart
`timescale 1ns/10ps
`include "srd_cfg.svh"
module srd_ack_gate #(
    parameter int unsigned NREL = 7
) (
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            tick_i,
    input  wire logic            run_i,
    input  wire logic            blink_i,
    input  wire logic            long_i,
    input  wire logic [2:0]      nact_i,
    input  wire logic [NREL-1:0] rel_in_i,
    input  wire logic            ack_i,
    output logic                 cond_o,
    output logic                 req_o,
    output logic                 rel_o
);
    initial if (NREL < 1 || NREL > 7) $error("srd_ack_gate: NREL out of range");

    logic [NREL-1:0] act_mask;
    logic            cond_now;
    logic [14:0]     wid_q;
    logic            ack_q;
    logic            ack_ok;
    logic [14:0]     wid_min;
    logic            rel_q;

    // inactive inputs count as high in the AND
    always_comb
    begin
        for (int i = 0; i < NREL; i++)
            act_mask[i] = (i < int'(nact_i));
        cond_now = &(rel_in_i | ~act_mask);
    end

    // width check done on the falling edge of the acknowledge
    assign wid_min = long_i ? 15'(`SRD_ACK_LONG_MS) : 15'(`SRD_ACK_SHORT_MS);
    assign ack_ok  = ack_q && !ack_i && wid_q >= wid_min
                     && wid_q <= 15'(`SRD_ACK_MAX_MS);

    // pulse width in logic cycles, saturating one past the limit
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wid_q <= 15'h0000;
            ack_q <= 1'b0;
        end
        else if (!run_i)
        begin
            wid_q <= 15'h0000;
            ack_q <= 1'b0;
        end
        else if (tick_i)
        begin
            ack_q <= ack_i;
            if (!ack_i)
                wid_q <= 15'h0000;
            else if (wid_q <= 15'(`SRD_ACK_MAX_MS))
                wid_q <= wid_q + 15'h0001;
        end
    end

    // release: set only by a valid pulse, dropped by any active input low
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rel_q <= 1'b0;
        else if (!run_i)
            rel_q <= 1'b0;
        else if (tick_i)
        begin
            if (!cond_now)
                rel_q <= 1'b0;
            else if (ack_ok)
                rel_q <= 1'b1;
        end
    end

    // indicator outputs follow the same logic cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cond_o <= 1'b0;
            req_o  <= 1'b0;
        end
        else if (tick_i)
        begin
            cond_o <= cond_now && run_i;
            req_o  <= cond_now && run_i && !rel_q && !ack_ok && blink_i;
        end
    end

    assign rel_o = rel_q;
endmodule

// ### hdl/srd_top.sv
// safety release top: two acknowledge gates and two off-delay timers
`timescale 1ns/10ps
`include "srd_cfg.svh"
module srd_top #(
    parameter int unsigned NREL       = 7,
    parameter int unsigned CYC_PER_MS = `SRD_CLK_HZ / 1000000 * `SRD_LOGIC_US
) (
    input  wire logic            clock_i,
    input  wire logic            reset_n_i,
    input  wire logic [7:0]      addr_i,
    input  wire logic [31:0]     wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic      [31:0]     rdata_o,
    input  wire logic [NREL-1:0] rst_rel_in_i,
    input  wire logic            rst_ack_i,
    output logic                 rst_cond_o,
    output logic                 rst_req_o,
    output logic                 rst_rel_o,
    input  wire logic [NREL-1:0] rsr_rel_in_i,
    input  wire logic            rsr_ack_i,
    output logic                 rsr_cond_o,
    output logic                 rsr_req_o,
    output logic                 rsr_rel_o,
    input  wire logic            fix_in_i,
    output logic                 fix_rel_o,
    output logic      [23:0]     fix_remain_o,
    input  wire logic            adj_ctl_i,
    input  wire logic [3:0]      adj_sel_i,
    output logic                 adj_rel_o,
    output logic                 adj_tchg_o,
    output logic      [23:0]     adj_remain_o
);
    initial if (CYC_PER_MS < 1 || CYC_PER_MS > 65535) $error("srd_top: CYC_PER_MS range");

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rsync_q;
    logic       rst_n;

    // async assert, two-flop release so all flops leave reset together
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rsync_q <= 2'b00;
        else
            rsync_q <= {rsync_q[0], 1'b1};
    end

    assign rst_n = rsync_q[1];

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic        run_q;
    logic        rst_long_q;
    logic        rsr_long_q;
    logic [2:0]  rst_nact_q;
    logic [2:0]  rsr_nact_q;
    logic [14:0] fix_dly_q;
    logic [15:0] adj_dly_q [4];
    logic [31:0] rd_d;

    // software writes; delays in 10 ms steps, out-of-range values clamp
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q      <= 1'b0;
            rst_long_q <= 1'b0;
            rsr_long_q <= 1'b0;
            rst_nact_q <= `SRD_NACT_RST;
            rsr_nact_q <= `SRD_NACT_RST;
            fix_dly_q  <= 15'h0000;
            for (int i = 0; i < 4; i++)
                adj_dly_q[i] <= `SRD_DLY_RST;
        end
        else if (wr_i)
        begin
            if (addr_i == `SRD_OFS_CTRL)
            begin
                run_q      <= wdata_i[`SRD_CTRL_RUN];
                rst_long_q <= wdata_i[`SRD_CTRL_RSTL];
                rsr_long_q <= wdata_i[`SRD_CTRL_RSRL];
                rst_nact_q <= wdata_i[`SRD_CTRL_RSTN +: 3];
                rsr_nact_q <= wdata_i[`SRD_CTRL_RSRN +: 3];
            end
            else if (addr_i == `SRD_OFS_FIX)
                fix_dly_q <= (wdata_i > 32'(`SRD_FIX_MAX)) ?
                             15'(`SRD_FIX_MAX) : wdata_i[14:0];
            else if (addr_i >= `SRD_OFS_ADJ0 && addr_i < `SRD_OFS_STATUS
                     && addr_i[1:0] == 2'b00)
                adj_dly_q[addr_i[3:2] - 2'h2] <= (wdata_i > 32'(`SRD_ADJ_MAX)) ?
                             16'(`SRD_ADJ_MAX) : wdata_i[15:0];
        end
    end

    // read decode; unmapped addresses read zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (addr_i == `SRD_OFS_CTRL)
        begin
            rd_d[`SRD_CTRL_RUN]       = run_q;
            rd_d[`SRD_CTRL_RSTL]      = rst_long_q;
            rd_d[`SRD_CTRL_RSRL]      = rsr_long_q;
            rd_d[`SRD_CTRL_RSTN +: 3] = rst_nact_q;
            rd_d[`SRD_CTRL_RSRN +: 3] = rsr_nact_q;
        end
        else if (addr_i == `SRD_OFS_FIX)
            rd_d[14:0] = fix_dly_q;
        else if (addr_i >= `SRD_OFS_ADJ0 && addr_i < `SRD_OFS_STATUS
                 && addr_i[1:0] == 2'b00)
            rd_d[15:0] = adj_dly_q[addr_i[3:2] - 2'h2];
        else if (addr_i == `SRD_OFS_STATUS)
            rd_d[8:0] = {adj_tchg_o, adj_rel_o, fix_rel_o, rsr_rel_o,
                         rsr_req_o, rsr_cond_o, rst_rel_o, rst_req_o, rst_cond_o};
        else if (addr_i == `SRD_OFS_FIXREM)
            rd_d[23:0] = fix_remain_o;
        else if (addr_i == `SRD_OFS_ADJREM)
            rd_d[23:0] = adj_remain_o;
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
            rdata_o <= rd_d;
        else
            rdata_o <= 32'h0000_0000;
    end

    // ---------------------------------------------------------------
    // logic cycle tick and 1 Hz blink
    // ---------------------------------------------------------------
    logic [15:0] div_q;
    logic        tick;
    logic [9:0]  blink_cnt_q;
    logic        blink_q;

    // one enable pulse per millisecond logic cycle
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= 16'h0000;
        else if (div_q == 16'(CYC_PER_MS - 1))
            div_q <= 16'h0000;
        else
            div_q <= div_q + 16'h0001;
    end

    assign tick = (div_q == 16'(CYC_PER_MS - 1));

    // toggles every 500 logic cycles, giving a 1 Hz square wave
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_cnt_q <= 10'h000;
            blink_q     <= 1'b0;
        end
        else if (tick)
        begin
            if (blink_cnt_q == 10'(`SRD_BLINK_MS - 1))
            begin
                blink_cnt_q <= 10'h000;
                blink_q     <= !blink_q;
            end
            else
                blink_cnt_q <= blink_cnt_q + 10'h001;
        end
    end

    // ---------------------------------------------------------------
    // acknowledge gates
    // ---------------------------------------------------------------
    srd_ack_gate #(.NREL(NREL)) u_reset (
        .clk_i    (clock_i),
        .rst_n_i  (rst_n),
        .tick_i   (tick),
        .run_i    (run_q),
        .blink_i  (blink_q),
        .long_i   (rst_long_q),
        .nact_i   (rst_nact_q),
        .rel_in_i (rst_rel_in_i),
        .ack_i    (rst_ack_i),
        .cond_o   (rst_cond_o),
        .req_o    (rst_req_o),
        .rel_o    (rst_rel_o)
    );

    // restart gate is the same logic with its own pins and setting
    srd_ack_gate #(.NREL(NREL)) u_restart (
        .clk_i    (clock_i),
        .rst_n_i  (rst_n),
        .tick_i   (tick),
        .run_i    (run_q),
        .blink_i  (blink_q),
        .long_i   (rsr_long_q),
        .nact_i   (rsr_nact_q),
        .rel_in_i (rsr_rel_in_i),
        .ack_i    (rsr_ack_i),
        .cond_o   (rsr_cond_o),
        .req_o    (rsr_req_o),
        .rel_o    (rsr_rel_o)
    );

    // ---------------------------------------------------------------
    // fixed off-delay
    // ---------------------------------------------------------------
    srd_pkg::srd_dly_state_t fix_st_q;
    logic                    fix_prev_q;
    logic [23:0]             fix_load;

    // 10 ms steps always exceed one 1 ms logic cycle
    assign fix_load = 24'(fix_dly_q) * 24'(`SRD_STEP_MS);

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fix_st_q     <= srd_pkg::SRD_OFF;
            fix_prev_q   <= 1'b0;
            fix_rel_o    <= 1'b0;
            fix_remain_o <= 24'h000000;
        end
        else if (!run_q)
        begin
            fix_st_q     <= srd_pkg::SRD_OFF;
            fix_prev_q   <= 1'b0;
            fix_rel_o    <= 1'b0;
            fix_remain_o <= 24'h000000;
        end
        else if (tick)
        begin
            fix_prev_q <= fix_in_i;
            case (fix_st_q)
                srd_pkg::SRD_HOLD,
                srd_pkg::SRD_OFF:
                begin
                    if (fix_in_i)
                    begin
                        fix_st_q     <= srd_pkg::SRD_HOLD;
                        fix_rel_o    <= 1'b1;
                        fix_remain_o <= 24'h000000;
                    end
                    else if (fix_prev_q && fix_load != 24'h000000)
                    begin
                        fix_st_q     <= srd_pkg::SRD_RUN;
                        fix_remain_o <= fix_load;
                    end
                    else
                    begin
                        fix_st_q  <= srd_pkg::SRD_OFF;
                        fix_rel_o <= 1'b0;
                    end
                end
                srd_pkg::SRD_RUN:
                begin
                    if (fix_in_i)
                    begin
                        fix_st_q     <= srd_pkg::SRD_HOLD;
                        fix_remain_o <= 24'h000000;
                    end
                    else if (fix_remain_o == 24'h000001)
                    begin
                        fix_st_q     <= srd_pkg::SRD_OFF;
                        fix_rel_o    <= 1'b0;
                        fix_remain_o <= 24'h000000;
                    end
                    else
                        fix_remain_o <= fix_remain_o - 24'h000001;
                end
                default:
                    fix_st_q <= srd_pkg::SRD_OFF;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // adjustable off-delay
    // ---------------------------------------------------------------
    srd_pkg::srd_dly_state_t adj_st_q;
    logic                    adj_prev_q;
    logic [3:0]              adj_lat_q;
    logic [17:0]             adj_sum;
    logic [23:0]             adj_load;

    // total of the selected delays, capped at 600 s
    always_comb
    begin
        adj_sum = 18'h00000;
        for (int i = 0; i < 4; i++)
            if (adj_sel_i[i])
                adj_sum = adj_sum + 18'(adj_dly_q[i]);
        if (adj_sum > 18'(`SRD_ADJ_MAX))
            adj_sum = 18'(`SRD_ADJ_MAX);
        adj_load = 24'(adj_sum) * 24'(`SRD_STEP_MS);
    end

    // prev starts low, so a low control in the first run cycle never loads
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adj_st_q     <= srd_pkg::SRD_OFF;
            adj_prev_q   <= 1'b0;
            adj_lat_q    <= 4'h0;
            adj_rel_o    <= 1'b0;
            adj_remain_o <= 24'h000000;
        end
        else if (!run_q)
        begin
            adj_st_q     <= srd_pkg::SRD_OFF;
            adj_prev_q   <= 1'b0;
            adj_rel_o    <= 1'b0;
            adj_remain_o <= 24'h000000;
        end
        else if (tick)
        begin
            adj_prev_q <= adj_ctl_i;
            case (adj_st_q)
                srd_pkg::SRD_HOLD,
                srd_pkg::SRD_OFF:
                begin
                    if (adj_ctl_i)
                    begin
                        adj_st_q     <= srd_pkg::SRD_HOLD;
                        adj_rel_o    <= 1'b1;
                        adj_remain_o <= 24'h000000;
                    end
                    else if (adj_prev_q)
                    begin
                        adj_lat_q <= adj_sel_i;
                        if (adj_load != 24'h000000)
                        begin
                            adj_st_q     <= srd_pkg::SRD_RUN;
                            adj_remain_o <= adj_load;
                        end
                        else
                        begin
                            adj_st_q  <= srd_pkg::SRD_OFF;
                            adj_rel_o <= 1'b0;
                        end
                    end
                    else
                    begin
                        adj_st_q  <= srd_pkg::SRD_OFF;
                        adj_rel_o <= 1'b0;
                    end
                end
                srd_pkg::SRD_RUN:
                begin
                    if (adj_ctl_i)
                    begin
                        adj_st_q     <= srd_pkg::SRD_HOLD;
                        adj_remain_o <= 24'h000000;
                    end
                    else if (adj_remain_o == 24'h000001)
                    begin
                        adj_st_q     <= srd_pkg::SRD_OFF;
                        adj_rel_o    <= 1'b0;
                        adj_remain_o <= 24'h000000;
                    end
                    else
                        adj_remain_o <= adj_remain_o - 24'h000001;
                end
                default:
                    adj_st_q <= srd_pkg::SRD_OFF;
            endcase
        end
    end

    // time change: select moved while running, held until control high
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            adj_tchg_o <= 1'b0;
        else if (!run_q)
            adj_tchg_o <= 1'b0;
        else if (tick)
        begin
            if (adj_st_q == srd_pkg::SRD_RUN && !adj_ctl_i
                && adj_sel_i != adj_lat_q)
                adj_tchg_o <= 1'b1;
            else if (adj_ctl_i)
                adj_tchg_o <= 1'b0;
        end
    end
endmodule

// ### verif/srd_top_sva.sv
// assertion checker for the safety release top
`timescale 1ns/10ps
module srd_top_sva #(
    parameter int unsigned NREL = 7
) (
    input wire logic            clock_i,
    input wire logic            reset_n_i,
    input wire logic [7:0]      addr_i,
    input wire logic [31:0]     wdata_i,
    input wire logic            wr_i,
    input wire logic [NREL-1:0] rst_rel_in_i,
    input wire logic            rst_ack_i,
    input wire logic            rst_cond_o,
    input wire logic            rst_req_o,
    input wire logic            rst_rel_o,
    input wire logic            fix_in_i,
    input wire logic            fix_rel_o,
    input wire logic [23:0]     fix_remain_o,
    input wire logic            adj_ctl_i,
    input wire logic            adj_rel_o,
    input wire logic            adj_tchg_o,
    input wire logic [23:0]     adj_remain_o
);
    // ----
    // run mirror and properties
    // ----
    logic run_q;
    // timers are only live in run, so track the run bit as software writes it
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            run_q <= 1'b0;
        else if (wr_i && addr_i == 8'h00)
            run_q <= wdata_i[0];
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    AST_REL_COND: assert property (rst_rel_o |-> rst_cond_o)
        else $error("release without condition");
    AST_REQ_IDLE: assert property (rst_req_o |-> rst_cond_o && !rst_rel_o)
        else $error("request outside waiting state");
    AST_REL_RISE: assert property ($rose(rst_rel_o) |-> !$past(rst_ack_i) && $past(rst_ack_i, 5))
        else $error("release rose without ack falling");
    AST_REL_DROP: assert property ((run_q && !(&rst_rel_in_i))[*5] |-> !rst_rel_o && !rst_cond_o)
        else $error("release held with an input low");
    AST_FIX_HIGH: assert property ((run_q && fix_in_i)[*6] |-> fix_rel_o && fix_remain_o == 24'h0)
        else $error("fixed timer not cleared by input");
    AST_FIX_COUNT: assert property ($changed(fix_remain_o) && fix_remain_o != 24'h0
        && $past(fix_remain_o) != 24'h0 |-> fix_remain_o == $past(fix_remain_o) - 24'h1)
        else $error("remaining time not stepping by one");
    AST_REMAIN_MAX: assert property (fix_remain_o <= 24'h0493e0 && adj_remain_o <= 24'h0927c0)
        else $error("remaining time out of range");
    AST_TCHG_RISE: assert property ($rose(adj_tchg_o) |-> $past(adj_rel_o) && !$past(adj_ctl_i))
        else $error("time change outside a sequence");
    AST_TCHG_CLEAR: assert property ((run_q && adj_ctl_i)[*5] |-> !adj_tchg_o && adj_rel_o)
        else $error("control high did not clear");
    cover property ($rose(rst_rel_o));
    cover property ($rose(adj_tchg_o));
    cover property ($fell(fix_rel_o));
endmodule
bind srd_top srd_top_sva #(.NREL(NREL)) u_sva (.clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
    .rst_rel_in_i, .rst_ack_i, .rst_cond_o, .rst_req_o, .rst_rel_o, .fix_in_i, .fix_rel_o,
    .fix_remain_o, .adj_ctl_i, .adj_rel_o, .adj_tchg_o, .adj_remain_o);

// ### verif/srd_button_model.sv
// operator acknowledge button model
`timescale 1ns/10ps
module srd_button_model (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        go_i,
    input  wire logic [15:0] len_i,
    output logic             ack_o
);
    logic [15:0] cnt_q;
    // press for len_i clocks, then release to low so a stale level never lingers
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 16'h0000;
            ack_o <= 1'b0;
        end
        else if (go_i)
        begin
            cnt_q <= len_i;
            ack_o <= 1'b1;
        end
        else if (cnt_q > 16'h0001)
            cnt_q <= cnt_q - 16'h0001;
        else
            ack_o <= 1'b0;
    end
endmodule

// ### verif/srd_top_bench.sv
// self-checking bench for the safety release top
`timescale 1ns/10ps
module srd_top_bench;
    localparam int CPM = 4;
    logic        clock_i, reset_n_i, wr_i, rd_i, fix_in_i, adj_ctl_i, rst_go, rsr_go;
    logic        rst_ack_i, rsr_ack_i, rst_cond_o, rst_req_o, rst_rel_o;
    logic        rsr_cond_o, rsr_req_o, rsr_rel_o, fix_rel_o, adj_rel_o, adj_tchg_o;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [6:0]  rst_rel_in_i, rsr_rel_in_i;
    logic [3:0]  adj_sel_i;
    logic [15:0] rst_len, rsr_len;
    logic [23:0] fix_remain_o, adj_remain_o;
    int          n_mismatch, compares, k;
    srd_top #(.CYC_PER_MS(CPM)) DUT (.clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .rst_rel_in_i, .rst_ack_i, .rst_cond_o, .rst_req_o, .rst_rel_o, .rsr_rel_in_i,
        .rsr_ack_i, .rsr_cond_o, .rsr_req_o, .rsr_rel_o, .fix_in_i, .fix_rel_o, .fix_remain_o,
        .adj_ctl_i, .adj_sel_i, .adj_rel_o, .adj_tchg_o, .adj_remain_o);
    srd_button_model u_rst (.clock_i, .rst_n_i(reset_n_i), .go_i(rst_go), .len_i(rst_len),
        .ack_o(rst_ack_i));
    srd_button_model u_rsr (.clock_i, .rst_n_i(reset_n_i), .go_i(rsr_go), .len_i(rsr_len),
        .ack_o(rsr_ack_i));
    // ----
    // clock, watchdog and bus tasks
    // ----
    // 25 ns period
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // whole run needs about 7300 clocks; give it margin
    initial
    begin
        #(25 * 30000);
        n_mismatch++;
        tally_and_finish();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            n_mismatch++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        chk(rdata_o, exp);
    endtask
    // wait n logic cycles, then settle at the falling edge
    task automatic tk(input int n);
        repeat (n * CPM) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    // both buttons pressed together, reset gate length a, restart gate length b
    task automatic press(input logic [15:0] a, input logic [15:0] b);
        @(posedge clock_i);
        rst_len <= a;
        rsr_len <= b;
        rst_go <= 1'b1;
        rsr_go <= 1'b1;
        @(posedge clock_i);
        rst_go <= 1'b0;
        rsr_go <= 1'b0;
        tk(360);
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----
    // test sequence
    // ----
    initial
    begin
        {reset_n_i, wr_i, rd_i, fix_in_i, adj_ctl_i, rst_go, rsr_go} = 7'h0;
        {addr_i, wdata_i, rst_rel_in_i, rsr_rel_in_i, adj_sel_i, rst_len, rsr_len} = 90'h0;
        repeat (4) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        wr(8'h00, 32'h00000175);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h2);
        wr(8'h0c, 32'h3);
        wr(8'h10, 32'h0000ea60);
        wr(8'h14, 32'h00012345);
        rd(8'h00, 32'h00000175);
        rd(8'h40, 32'h0);
        rd(8'h14, 32'h0000ea60);
        $display("test registers done");
        @(posedge clock_i);
        rst_rel_in_i <= 7'h7f;
        rsr_rel_in_i <= 7'h01;
        tk(2);
        chk(32'({rst_cond_o, rst_rel_o, rsr_cond_o, rsr_rel_o}), 32'ha);
        press(16'd396, 16'd1396);
        chk(32'({rst_rel_o, rsr_rel_o}), 32'h0);
        k = 0;
        repeat (1000 * CPM)
        begin
            @(negedge clock_i);
            k += int'(rst_req_o);
        end
        chk(32'(k), 32'h7d0);
        press(16'd400, 16'd1400);
        chk(32'({rst_rel_o, rsr_rel_o, rst_req_o, rsr_req_o}), 32'hc);
        rd(8'h18, 32'h0000002d);
        @(posedge clock_i);
        rst_rel_in_i <= 7'h3f;
        rsr_rel_in_i <= 7'h7e;
        tk(2);
        chk(32'({rst_cond_o, rst_rel_o, rsr_cond_o, rsr_rel_o}), 32'h0);
        @(posedge clock_i);
        rst_rel_in_i <= 7'h7f;
        rsr_rel_in_i <= 7'h01;
        tk(2);
        chk(32'({rst_cond_o, rst_rel_o, rsr_cond_o, rsr_rel_o}), 32'ha);
        $display("test gates done");
        @(posedge clock_i);
        fix_in_i <= 1'b1;
        tk(3);
        chk(32'({fix_rel_o, fix_remain_o}), 32'h01000000);
        @(posedge clock_i);
        fix_in_i <= 1'b0;
        for (k = 0; k < 12 && fix_remain_o !== 24'ha; k++) @(negedge clock_i);
        repeat (9 * CPM) @(posedge clock_i);
        @(negedge clock_i);
        chk(32'({fix_rel_o, fix_remain_o}), 32'h01000001);
        tk(1);
        chk(32'({fix_rel_o, fix_remain_o}), 32'h0);
        $display("test fixed done");
        @(posedge clock_i);
        adj_ctl_i <= 1'b1;
        adj_sel_i <= 4'h3;
        tk(3);
        @(posedge clock_i);
        adj_ctl_i <= 1'b0;
        for (k = 0; k < 12 && adj_remain_o !== 24'h32; k++) @(negedge clock_i);
        @(posedge clock_i);
        adj_sel_i <= 4'h1;
        repeat (48 * CPM + 3) @(posedge clock_i);
        @(negedge clock_i);
        chk(32'({adj_tchg_o, adj_rel_o, adj_remain_o}), 32'h03000001);
        tk(1);
        chk(32'({adj_tchg_o, adj_rel_o, adj_remain_o}), 32'h02000000);
        @(posedge clock_i);
        adj_ctl_i <= 1'b1;
        adj_sel_i <= 4'hc;
        tk(2);
        chk(32'({adj_tchg_o, adj_rel_o, adj_remain_o}), 32'h01000000);
        @(posedge clock_i);
        adj_ctl_i <= 1'b0;
        for (k = 0; k < 12 && adj_remain_o === 24'h0; k++) @(negedge clock_i);
        chk(32'(adj_remain_o), 32'h000927c0);
        rd(8'h20, 32'h000927c0);
        $display("test adjustable done");
        wr(8'h00, 32'h00000174);
        wr(8'h00, 32'h00000175);
        tk(3);
        chk(32'({adj_rel_o, fix_rel_o, rst_rel_o, rst_cond_o}), 32'h1);
        $display("test run entry done");
        tally_and_finish();
    end
endmodule
